// [hw/tcsos_status.sv]
`timescale 1ns/10ps
// Summary of operation
// - Each output terminal reports a monitored bit, 1 when on, 0 when off.
// - Each output terminal reports a status bit, 0 on fault, 1 when fault free.
// - Aggregate output health is 0 on any terminal fault, 1 only when all normal.
// - Connection-active flag is 1 while the safety link is up, default 0.
// - Module-normal flag is 1 with no module error, 0 on any error.
// - Supply error flag is 1 when I/O supply is off or out of range.

// ==========================================================
// Pin filter: three synchroniser flip-flops and an output flop, change accepted when two agree
// ==========================================================
module tcsos_pin_filter #(
    parameter int WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);
    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;
    logic [WIDTH-1:0] filt_r;

    // The first stage feeds only the second, so no logic sees a metastable level.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1_r <= '0;
            stage2_r <= '0;
            stage3_r <= '0;
        end else begin
            stage1_r <= pin_in;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_r <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2_r[i] == stage3_r[i]) begin
                    filt_r[i] <= stage3_r[i];
                end
            end
        end
    end

    assign pin_out = filt_r;
endmodule : tcsos_pin_filter

// ==========================================================
// Status image with APB register access
// ==========================================================
module tcsos_status (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire tcsos_pkg::tcsos_pins_t pins
);
    import tcsos_pkg::*;

    tcsos_pins_t filt;
    tcsos_image_t image_r;
    tcsos_image_t image_nxt;
    logic [7:0] ctrl_r;
    logic [31:0] prdata_r;
    logic [TCSOS_TERMINALS-1:0] fault_free;
    logic [TCSOS_TERMINALS-1:0] monitored;
    logic [TCSOS_TERMINALS-1:0] fault_raw;
    logic setup;
    logic access;
    logic addr_hit;
    logic ro_write;

    // ==========================================================
    // Pin conditioning
    // ==========================================================
    tcsos_pin_filter #(
        .WIDTH(TCSOS_PIN_W)
    ) u_filter (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(pins),
        .pin_out(filt)
    );

    // ==========================================================
    // Image assembly
    // ==========================================================
    assign monitored = {filt.out1_monitored_state, filt.out0_monitored_state};
    assign fault_raw = {filt.out1_fault, filt.out0_fault};

    generate
        for (genvar t = 0; t < TCSOS_TERMINALS; t++) begin : g_term
            assign fault_free[t] = ~fault_raw[t];
        end
    endgenerate

    always_comb begin
        image_nxt.low = TCSOS_IMG_RST;
        image_nxt.high = TCSOS_IMG_RST;
        image_nxt.low[TCSOS_LOW_MON0 +: TCSOS_TERMINALS] = monitored;
        image_nxt.low[TCSOS_LOW_CONN] = filt.link_established;
        image_nxt.low[TCSOS_LOW_HEALTH] = &fault_free;
        image_nxt.low[TCSOS_LOW_NORMAL] = ~filt.module_error;
        image_nxt.low[TCSOS_LOW_SUPPLY] = filt.supply_bad;
        image_nxt.high[TCSOS_HIGH_OK0 +: TCSOS_TERMINALS] = fault_free;
    end

    // Both bytes load on the same edge, but they are read in separate transfers, so only a cleared update bit rules out a torn image.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            image_r.low <= TCSOS_IMG_RST;
            image_r.high <= TCSOS_IMG_RST;
        end else if (ctrl_r[TCSOS_CTRL_UPDATE]) begin
            image_r <= image_nxt;
        end
    end

    // ==========================================================
    // APB slave
    // ==========================================================
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign addr_hit = (paddr == TCSOS_OFS_IMG_LOW) | (paddr == TCSOS_OFS_IMG_HIGH) | (paddr == TCSOS_OFS_CTRL);
    assign ro_write = pwrite & ((paddr == TCSOS_OFS_IMG_LOW) | (paddr == TCSOS_OFS_IMG_HIGH));
    assign pready = 1'b1;
    assign pslverr = access & (~addr_hit | ro_write);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= TCSOS_CTRL_RST;
        end else if (access && pwrite && paddr == TCSOS_OFS_CTRL) begin
            ctrl_r <= {7'h00, pwdata[TCSOS_CTRL_UPDATE]};
        end
    end

    // Read data is captured in the setup cycle so it leaves a flip-flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h00000000;
        end else if (setup) begin
            case (paddr)
                TCSOS_OFS_IMG_LOW: prdata_r <= {24'h000000, image_r.low};
                TCSOS_OFS_IMG_HIGH: prdata_r <= {24'h000000, image_r.high};
                TCSOS_OFS_CTRL: prdata_r <= {24'h000000, ctrl_r};
                default: prdata_r <= 32'h00000000;
            endcase
        end
    end

    assign prdata = prdata_r;

    // ==========================================================
    // Checks
    // ==========================================================
    mon_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_r[TCSOS_CTRL_UPDATE] |=> image_r.low[TCSOS_LOW_MON0] == $past(filt.out0_monitored_state))
        else $error("Monitored bit of terminal zero did not follow its pin.");

    status_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_r[TCSOS_CTRL_UPDATE] |=> image_r.high[TCSOS_HIGH_OK0 + 1] == !$past(filt.out1_fault))
        else $error("Status bit of terminal one does not mirror its fault.");

    health_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_r[TCSOS_CTRL_UPDATE] && (filt.out0_fault || filt.out1_fault)) |=> !image_r.low[TCSOS_LOW_HEALTH])
        else $error("Health flag stayed high with a terminal fault.");

    health_and_a: assert property (@(posedge pclk) disable iff (!presetn)
        image_r.low[TCSOS_LOW_HEALTH] == &image_r.high[TCSOS_HIGH_OK0 +: TCSOS_TERMINALS])
        else $error("Health flag disagrees with the terminal status bits.");

    conn_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(filt.link_established) && ctrl_r[TCSOS_CTRL_UPDATE]) |=> image_r.low[TCSOS_LOW_CONN])
        else $error("Connection flag did not rise with the link.");

    normal_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_r[TCSOS_CTRL_UPDATE] |=> image_r.low[TCSOS_LOW_NORMAL] != $past(filt.module_error))
        else $error("Module normal flag does not oppose the module error.");

    supply_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pins.supply_bad && ctrl_r[TCSOS_CTRL_UPDATE]) [*6] |-> image_r.low[TCSOS_LOW_SUPPLY])
        else $error("Supply error flag missing after a steady supply fault.");

    image_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_r[TCSOS_CTRL_UPDATE] |=> $stable(image_r))
        else $error("Image changed while updates were held.");

    mon1_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_r[TCSOS_CTRL_UPDATE] |=> image_r.low[TCSOS_LOW_MON1] == $past(filt.out1_monitored_state))
        else $error("Monitored bit of terminal one did not follow its pin.");

    status0_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_r[TCSOS_CTRL_UPDATE] |=> image_r.high[TCSOS_HIGH_OK0] == !$past(filt.out0_fault))
        else $error("Status bit of terminal zero does not mirror its fault.");

    health_one_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_r[TCSOS_CTRL_UPDATE] && !filt.out0_fault && !filt.out1_fault) |=> image_r.low[TCSOS_LOW_HEALTH])
        else $error("Health flag stayed low with all terminals normal.");

    conn_value_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_r[TCSOS_CTRL_UPDATE] |=> image_r.low[TCSOS_LOW_CONN] == $past(filt.link_established))
        else $error("Connection flag does not track the link.");

    supply_value_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_r[TCSOS_CTRL_UPDATE] |=> image_r.low[TCSOS_LOW_SUPPLY] == $past(filt.supply_bad))
        else $error("Supply error flag does not track the supply state.");

    // A refused write must leave the control register untouched.
    ctrl_guard_a: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr != TCSOS_OFS_CTRL) |=> ctrl_r == $past(ctrl_r))
        else $error("Control register changed on a refused write.");

endmodule : tcsos_status

// [hw/tcsos_pkg.sv]
package tcsos_pkg;

    // ==========================================================
    // Register map and field layout
    // ==========================================================
    localparam logic [11:0] TCSOS_OFS_IMG_LOW = 12'h000;
    localparam logic [11:0] TCSOS_OFS_IMG_HIGH = 12'h004;
    localparam logic [11:0] TCSOS_OFS_CTRL = 12'h008;

    localparam int TCSOS_LOW_MON0 = 0;
    localparam int TCSOS_LOW_MON1 = 1;
    localparam int TCSOS_LOW_CONN = 2;
    localparam int TCSOS_LOW_HEALTH = 3;
    localparam int TCSOS_LOW_NORMAL = 4;
    localparam int TCSOS_LOW_SUPPLY = 5;
    localparam int TCSOS_HIGH_OK0 = 0;
    localparam int TCSOS_CTRL_UPDATE = 0;

    localparam int TCSOS_TERMINALS = 2;
    localparam int TCSOS_PIN_W = 7;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0] TCSOS_IMG_RST = 8'h00;
    localparam logic [7:0] TCSOS_CTRL_RST = 8'h01;
    localparam logic [TCSOS_PIN_W-1:0] TCSOS_PIN_RST = 7'h00;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic out0_monitored_state;
        logic out1_monitored_state;
        logic out1_fault;
        logic out0_fault;
        logic link_established;
        logic module_error;
        logic supply_bad;
    } tcsos_pins_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } tcsos_image_t;

endpackage : tcsos_pkg

// [verification/tcsos_field.sv]
`timescale 1ns/10ps
// ==========================================================
// Field side: terminal, link and supply levels
// ==========================================================
module tcsos_field (
    input wire logic pclk,
    input wire logic presetn,
    input wire tcsos_pkg::tcsos_pins_t want,
    output tcsos_pkg::tcsos_pins_t pins
);
    import tcsos_pkg::*;
    // Levels move just after an edge, so the synchroniser never sees a same-step race.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins <= '0;
        end else begin
            pins <= want;
        end
    end
endmodule : tcsos_field

// [verification/tb.sv]
`timescale 1ns/10ps
module tb;
    import tcsos_pkg::*;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    tcsos_pins_t want = '0;
    tcsos_pins_t pins;
    tcsos_pins_t held;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    int seed = 98;
    logic [31:0] rd;
    logic er;
    always #10 pclk = ~pclk;
    tcsos_field tcsos_field_inst (.pclk(pclk), .presetn(presetn), .want(want), .pins(pins));
    tcsos_status tcsos_status_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(pins));
    // ==========================================================
    // Reporting
    // ==========================================================
    task give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict
    // A hung handshake would otherwise stall the run forever.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            give_verdict();
        end
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // ==========================================================
    // Bus master and reference model
    // ==========================================================
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic [31:0] exp_low(input tcsos_pins_t p);
        return {26'h0, p.supply_bad, ~p.module_error, ~(p.out0_fault | p.out1_fault),
            p.link_established, p.out1_monitored_state, p.out0_monitored_state};
    endfunction : exp_low
    task chk_img(input tcsos_pins_t p);
        apb(1'b0, TCSOS_OFS_IMG_LOW, 32'h0);
        chk("low byte", rd, exp_low(p));
        chk("conn flag", {31'h0, rd[TCSOS_LOW_CONN]}, {31'h0, p.link_established});
        chk("low read err", {31'h0, er}, 32'h0);
        apb(1'b0, TCSOS_OFS_IMG_HIGH, 32'h0);
        chk("high byte", rd, {30'h0, ~p.out1_fault, ~p.out0_fault});
        chk("high read err", {31'h0, er}, 32'h0);
    endtask : chk_img
    // ==========================================================
    // Scenarios
    // ==========================================================
    initial begin
        repeat (6) @(posedge pclk);
        chk("reset rdata", prdata, 32'h0);
        presetn <= 1'b1;
        chk_img('0);
        apb(1'b0, TCSOS_OFS_CTRL, 32'h0);
        chk("ctrl reset", rd, 32'h1);
        $display("reset test done");
        for (int i = 0; i < 16; i++) begin
            @(posedge pclk);
            want <= (i == 0) ? 7'h64 : 7'($random(seed));
            repeat (8) @(posedge pclk);
            chk_img(want);
        end
        $display("image test done");
        apb(1'b1, TCSOS_OFS_IMG_LOW, 32'hff);
        chk("ro write err", {31'h0, er}, 32'h1);
        apb(1'b0, 12'h00c, 32'h0);
        chk("unmapped err", {31'h0, er}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        chk_img(want);
        held = want;
        apb(1'b1, TCSOS_OFS_CTRL, 32'h0);
        want <= ~want;
        repeat (8) @(posedge pclk);
        chk_img(held);
        apb(1'b1, TCSOS_OFS_CTRL, 32'h1);
        repeat (8) @(posedge pclk);
        chk_img(want);
        $display("refusal and freeze test done");
        give_verdict();
    end
endmodule : tb
